// >>> src/dcr_regs.sv
`default_nettype none

module dcr_regs
  import dcr_pkg::*;
#(
  parameter int DATA_W = 14,
  parameter logic [3:0] HW_REVISION = 4'h5 // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic spi_csb_n,
  input wire logic spi_sclk,
  input wire logic spi_sdio_in,
  output logic spi_sdio_out,
  output logic spi_sdio_oe,
  output logic spi_sdo_out,
  output logic spi_sdo_oe,
  input wire logic sample_clock_in,
  input wire logic sample_clock_in_diff,
  input wire logic [DATA_W-1:0] sample_data_in,
  input wire logic [5:0] cal_trim_in,
  output logic [DATA_W-1:0] sample_code_out,
  output logic cal_clk_out,
  output logic ref_source_select,
  output logic clock_input_type
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  dcr_spi_state_t spi_state, next_spi_state;
  logic sclk_prev, next_sclk_prev;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] spi_shift, next_spi_shift;
  logic [4:0] spi_addr, next_spi_addr;
  logic spi_read, next_spi_read;
  logic [1:0] bytes_left, next_bytes_left;
  logic out_bit, next_out_bit;
  logic wr_en, next_wr_en;
  logic [4:0] wr_addr, next_wr_addr;
  logic [7:0] wr_data, next_wr_data;
  logic [7:0] spi_ctl, next_spi_ctl;
  logic [7:0] data_cfg, next_data_cfg;
  logic [2:0] cal_div, next_cal_div;
  logic [5:0] coef_address, next_coef_address;
  logic [5:0] coef_value, next_coef_value;
  logic [1:0] cal_memory_state, next_cal_memory_state;
  logic cal_busy, next_cal_busy;
  logic cal_done_flag, next_cal_done_flag;
  logic [5:0] cal_idx, next_cal_idx;
  logic [5:0] coef_mem [COEF_DEPTH];
  logic [5:0] next_coef_mem [COEF_DEPTH];
  logic samp_prev, next_samp_prev;
  logic [7:0] div_cnt, next_div_cnt;
  logic next_cal_clk_out;
  logic [DATA_W-1:0] retime_stage, next_retime_stage;
  logic [DATA_W-1:0] next_sample_code_out;

  logic sclk_rise, sclk_fall, soft_rst, reg_wr_cal;
  logic cal_go, coef_wr_go, coef_rd_go, restore_go;
  logic clk_pick, samp_rise, samp_fall, cap_edge, cal_tick;
  logic cal_clock_enable, input_code_format, latch_edge_select, input_retime;
  logic [7:0] div_mask;
  logic [7:0] instr;

  // Readback of one register by address
  function automatic logic [7:0] reg_read(input logic [4:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      ADDR_SPI_CTL: v = spi_ctl;
      ADDR_DATA_CFG: v = data_cfg;
      ADDR_HW_REV: v = {4'h0, HW_REVISION};
      ADDR_CAL_DIV: v = {2'h0, cal_memory_state, 1'b0, cal_div};
      ADDR_CAL_CTL: v = {cal_done_flag, cal_busy, 6'h00};
      ADDR_COEF_ADDR: v = {2'h0, coef_address};
      ADDR_COEF_DATA: v = {2'h0, coef_value};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Offset-binary code seen by the converter core
  function automatic logic [DATA_W-1:0] to_core_code(input logic [DATA_W-1:0] d,
                                                     input logic twos);
    return d ^ {twos, {(DATA_W-1){1'b0}}};
  endfunction

  // ---------------------------------------------------------------
  // Serial port
  // ---------------------------------------------------------------
  assign sclk_rise = spi_sclk & ~sclk_prev;
  assign sclk_fall = ~spi_sclk & sclk_prev;
  assign instr = {spi_shift[6:0], spi_sdio_in};

  // Instruction decode, shift in and shift out
  always_comb begin
    next_spi_state = spi_state;
    next_sclk_prev = spi_sclk;
    next_bit_cnt = bit_cnt;
    next_spi_shift = spi_shift;
    next_spi_addr = spi_addr;
    next_spi_read = spi_read;
    next_bytes_left = bytes_left;
    next_out_bit = out_bit;
    next_wr_en = 1'b0;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    if (spi_csb_n) begin
      next_spi_state = SPI_IDLE;
      next_bit_cnt = 3'h0;
      next_spi_read = 1'b0;
    end else begin
      unique case (spi_state)
        SPI_IDLE, SPI_INSTR: begin
          next_spi_state = SPI_INSTR;
          if (sclk_rise) begin
            next_spi_shift = instr;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == BIT_LAST) begin
              next_spi_state = SPI_DATA;
              next_spi_read = instr[INSTR_RW_BIT];
              next_bytes_left = instr[INSTR_CNT_LSB+:2];
              next_spi_addr = instr[ADDR_W-1:0];
              if (instr[INSTR_RW_BIT]) begin
                next_spi_shift = reg_read(instr[ADDR_W-1:0]);
                next_out_bit = next_spi_shift[7];
              end
            end
          end
        end
        SPI_DATA: begin
          if (sclk_rise) begin
            next_bit_cnt = bit_cnt + 3'h1;
            next_spi_shift = spi_read ? {spi_shift[6:0], 1'b0} : instr;
            if (bit_cnt == BIT_LAST) begin
              next_wr_en = ~spi_read;
              next_wr_addr = spi_addr;
              next_wr_data = instr;
              if (bytes_left == 2'h0) begin
                next_spi_state = SPI_DONE;
              end else begin
                // Multibyte walks the address downward
                next_spi_addr = spi_addr - 5'h01;
                next_bytes_left = bytes_left - 2'h1;
                if (spi_read) begin
                  next_spi_shift = reg_read(next_spi_addr);
                end
              end
            end
          end else if (sclk_fall && spi_read) begin
            next_out_bit = spi_shift[7];
          end
        end
        SPI_DONE: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      spi_state <= SPI_IDLE;
      sclk_prev <= 1'b0;
      bit_cnt <= 3'h0;
      spi_shift <= 8'h00;
      spi_addr <= 5'h00;
      spi_read <= 1'b0;
      bytes_left <= 2'h0;
      out_bit <= 1'b0;
      wr_en <= 1'b0;
      wr_addr <= 5'h00;
      wr_data <= 8'h00;
    end else begin
      spi_state <= next_spi_state;
      sclk_prev <= next_sclk_prev;
      bit_cnt <= next_bit_cnt;
      spi_shift <= next_spi_shift;
      spi_addr <= next_spi_addr;
      spi_read <= next_spi_read;
      bytes_left <= next_bytes_left;
      out_bit <= next_out_bit;
      wr_en <= next_wr_en;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
    end
  end

  // Read data goes out on the three-wire or four-wire pin
  assign spi_sdio_out = out_bit;
  assign spi_sdo_out = out_bit;
  assign spi_sdio_oe = spi_read & ~spi_csb_n & spi_ctl[SDIO_DIR_BIT];
  assign spi_sdo_oe = spi_read & ~spi_csb_n & ~spi_ctl[SDIO_DIR_BIT];

  // ---------------------------------------------------------------
  // Register bank, calibration and coefficient memory
  // ---------------------------------------------------------------
  assign soft_rst = spi_ctl[SOFT_RESET_BIT_BIT];
  assign reg_wr_cal = wr_en && (wr_addr == ADDR_CAL_CTL) && !soft_rst;
  assign cal_go = reg_wr_cal && wr_data[CAL_START_BIT];
  assign coef_wr_go = reg_wr_cal && wr_data[COEF_WR_BIT];
  assign coef_rd_go = reg_wr_cal && wr_data[COEF_RD_BIT];
  assign restore_go = reg_wr_cal && wr_data[COEF_RESTORE_BIT];
  assign input_code_format = data_cfg[FMT_BIT];
  assign latch_edge_select = data_cfg[EDGE_BIT];
  assign input_retime = data_cfg[RETIME_BIT];
  assign clock_input_type = data_cfg[CLK_TYPE_BIT];
  assign cal_clock_enable = data_cfg[CAL_CLK_EN_BIT];
  assign ref_source_select = spi_ctl[REF_SEL_BIT];

  // Next values of the bank
  always_comb begin
    next_spi_ctl = spi_ctl;
    next_data_cfg = data_cfg;
    next_cal_div = cal_div;
    next_coef_address = coef_address;
    next_coef_value = coef_value;
    next_cal_memory_state = cal_memory_state;
    next_cal_busy = cal_busy;
    next_cal_done_flag = cal_done_flag;
    next_cal_idx = cal_idx;
    next_coef_mem = coef_mem;
    if (soft_rst) begin
      next_spi_ctl[SOFT_RESET_BIT_BIT] = 1'b0;
      next_data_cfg = DATA_CFG_RST;
      next_cal_div = CAL_DIV_RST;
      next_coef_address = COEF_ADDR_RST;
      next_coef_value = COEF_DATA_RST;
      next_cal_memory_state = CAL_ST_COEF_RESTORE_DEFAULT;
      next_cal_busy = 1'b0;
      next_cal_done_flag = 1'b0;
      next_cal_idx = COEF_ADDR_RST;
    end else begin
      if (wr_en) begin
        unique case (wr_addr)
          ADDR_SPI_CTL: next_spi_ctl = wr_data;
          ADDR_DATA_CFG: next_data_cfg = wr_data & DATA_CFG_MASK;
          ADDR_CAL_DIV: next_cal_div = wr_data[2:0];
          ADDR_COEF_ADDR: next_coef_address = wr_data[5:0];
          ADDR_COEF_DATA: next_coef_value = wr_data[5:0];
          default: begin
          end
        endcase
      end
      if (cal_go) begin
        next_cal_busy = 1'b1;
        next_cal_done_flag = 1'b0;
        next_cal_idx = COEF_ADDR_RST;
      end else if (cal_busy && cal_tick) begin
        next_coef_mem[cal_idx] = cal_trim_in;
        next_cal_idx = cal_idx + 6'h01;
        if (cal_idx == COEF_LAST) begin
          next_cal_busy = 1'b0;
          next_cal_done_flag = 1'b1;
          next_cal_memory_state = CAL_ST_SELF;
        end
      end
      if (coef_wr_go) begin
        next_coef_mem[coef_address] = coef_value;
        next_cal_memory_state = CAL_ST_USER;
      end
      if (coef_rd_go) begin
        next_coef_value = coef_mem[coef_address];
      end
      if (restore_go) begin
        for (int i = 0; i < COEF_DEPTH; i++) begin
          next_coef_mem[i] = COEF_COEF_RESTORE_DEFAULT;
        end
        next_cal_memory_state = CAL_ST_COEF_RESTORE_DEFAULT;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      spi_ctl <= SPI_CTL_RST;
      data_cfg <= DATA_CFG_RST;
      cal_div <= CAL_DIV_RST;
      coef_address <= COEF_ADDR_RST;
      coef_value <= COEF_DATA_RST;
      cal_memory_state <= CAL_ST_COEF_RESTORE_DEFAULT;
      cal_busy <= 1'b0;
      cal_done_flag <= 1'b0;
      cal_idx <= COEF_ADDR_RST;
      for (int i = 0; i < COEF_DEPTH; i++) begin
        coef_mem[i] <= COEF_COEF_RESTORE_DEFAULT;
      end
    end else begin
      spi_ctl <= next_spi_ctl;
      data_cfg <= next_data_cfg;
      cal_div <= next_cal_div;
      coef_address <= next_coef_address;
      coef_value <= next_coef_value;
      cal_memory_state <= next_cal_memory_state;
      cal_busy <= next_cal_busy;
      cal_done_flag <= next_cal_done_flag;
      cal_idx <= next_cal_idx;
      coef_mem <= next_coef_mem;
    end
  end

  // ---------------------------------------------------------------
  // Sample clock, calibration divider and data path
  // ---------------------------------------------------------------
  // clock input type
  assign clk_pick = clock_input_type ? sample_clock_in_diff : sample_clock_in;
  assign samp_rise = clk_pick & ~samp_prev;
  assign samp_fall = ~clk_pick & samp_prev;
  // divide by 256 shifted down by code
  assign div_mask = DIV_FULL_MASK >> cal_div;
  assign cal_tick = cal_clock_enable && samp_rise && ((div_cnt & div_mask) == div_mask);
  assign cap_edge = (input_retime && latch_edge_select) ? samp_fall : samp_rise;

  // Divider count and captured samples
  always_comb begin
    next_samp_prev = clk_pick;
    next_div_cnt = div_cnt;
    next_retime_stage = retime_stage;
    next_sample_code_out = sample_code_out;
    if (!cal_clock_enable) begin
      next_div_cnt = 8'h00;
    end else if (samp_rise) begin
      next_div_cnt = div_cnt + 8'h01;
    end
    next_cal_clk_out = cal_clock_enable && |(next_div_cnt & (div_mask ^ (div_mask >> 1)));
    if (input_retime) begin
      if (cap_edge) begin
        next_retime_stage = sample_data_in;
        next_sample_code_out = to_core_code(retime_stage, input_code_format);
      end
    end else if (samp_rise) begin
      next_sample_code_out = to_core_code(sample_data_in, input_code_format);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      samp_prev <= 1'b0;
      div_cnt <= 8'h00;
      cal_clk_out <= 1'b0;
      retime_stage <= '0;
      sample_code_out <= '0;
    end else begin
      samp_prev <= next_samp_prev;
      div_cnt <= next_div_cnt;
      cal_clk_out <= next_cal_clk_out;
      retime_stage <= next_retime_stage;
      sample_code_out <= next_sample_code_out;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Sample-clock rises between calibration ticks
  logic [8:0] gap_cnt;
  logic gap_valid;
  logic [2:0] gap_div;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_cnt <= 9'h000;
      gap_valid <= 1'b0;
      gap_div <= 3'h0;
    end else begin
      gap_div <= cal_div;
      if (!cal_clock_enable || gap_div != cal_div) begin
        gap_cnt <= 9'h000;
        gap_valid <= 1'b0;
      end else if (cal_tick) begin
        gap_cnt <= 9'h000;
        gap_valid <= 1'b1;
      end else if (samp_rise) begin
        gap_cnt <= gap_cnt + 9'h001;
      end
    end
  end

  property p_cal_clk_off;
    !cal_clock_enable |=> !cal_clk_out && div_cnt == 8'h00;
  endproperty
  a_cal_clk_off: assert property (p_cal_clk_off) else $error("cal clock runs while disabled");

  property p_div_period;
    cal_tick && gap_valid && gap_div == cal_div |-> gap_cnt == 9'((DIV_SPAN >> cal_div) - 1);
  endproperty
  a_div_period: assert property (p_div_period) else $error("cal divide ratio wrong");

  property p_cal_launch;
    cal_go |=> cal_busy && !cal_done_flag && cal_idx == 6'h00;
  endproperty
  a_cal_launch: assert property (p_cal_launch) else $error("calibration not launched");

  property p_cal_done;
    $rose(cal_done_flag) |-> $past(cal_busy) && !cal_busy && cal_memory_state == CAL_ST_SELF;
  endproperty
  a_cal_done: assert property (p_cal_done) else $error("done flag without finished cycle");

  property p_coef_write;
    coef_wr_go && !restore_go && !(cal_busy && cal_tick) |=>
      coef_mem[$past(coef_address)] == $past(coef_value) && cal_memory_state == CAL_ST_USER;
  endproperty
  a_coef_write: assert property (p_coef_write) else $error("coefficient write lost");

  // Word at the addressed location, watched by the read check
  logic [5:0] addr_word;
  assign addr_word = coef_mem[coef_address];

  property p_coef_read;
    coef_rd_go |=> coef_value == $past(addr_word);
  endproperty
  a_coef_read: assert property (p_coef_read) else $error("coefficient read wrong");

  property p_restore;
    restore_go |=> coef_mem[0] == COEF_COEF_RESTORE_DEFAULT && coef_mem[COEF_DEPTH-1] == COEF_COEF_RESTORE_DEFAULT
      && cal_memory_state == CAL_ST_COEF_RESTORE_DEFAULT;
  endproperty
  a_restore: assert property (p_restore) else $error("restore left coefficients");

  property p_soft_reset;
    soft_rst |=> data_cfg == DATA_CFG_RST && coef_value == COEF_DATA_RST
      && coef_address == COEF_ADDR_RST && spi_ctl == ($past(spi_ctl) & ~8'h20);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset result wrong");

  c_cal_done: cover property ($rose(cal_done_flag));
  c_coef_write: cover property (coef_wr_go);
  c_soft_reset: cover property (soft_rst);
  c_retime_fall: cover property (input_retime && latch_edge_select && cap_edge);

endmodule

`default_nettype wire

// >>> include/dcr_pkg.sv
`default_nettype none

package dcr_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_SPI_CTL = 5'h00;
  localparam logic [4:0] ADDR_DATA_CFG = 5'h02;
  localparam logic [4:0] ADDR_HW_REV = 5'h0d;
  localparam logic [4:0] ADDR_CAL_DIV = 5'h0e;
  localparam logic [4:0] ADDR_CAL_CTL = 5'h0f;
  localparam logic [4:0] ADDR_COEF_ADDR = 5'h10;
  localparam logic [4:0] ADDR_COEF_DATA = 5'h11;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SDIO_DIR_BIT = 7;
  localparam int SOFT_RESET_BIT_BIT = 5;
  localparam int REF_SEL_BIT = 0;
  localparam int FMT_BIT = 7;
  localparam int EDGE_BIT = 4;
  localparam int RETIME_BIT = 3;
  localparam int CLK_TYPE_BIT = 2;
  localparam int CAL_CLK_EN_BIT = 0;
  localparam int CAL_STATE_LSB = 4;
  localparam int CAL_DONE_BIT = 7;
  localparam int CAL_START_BIT = 6;
  localparam int COEF_WR_BIT = 3;
  localparam int COEF_RD_BIT = 2;
  localparam int COEF_RESTORE_BIT = 0;
  localparam int INSTR_RW_BIT = 7;
  localparam int INSTR_CNT_LSB = 5;

  // ---------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------
  localparam logic [7:0] SPI_CTL_RST = 8'h80;
  localparam logic [7:0] DATA_CFG_RST = 8'h00;
  localparam logic [7:0] DATA_CFG_MASK = 8'h9d;
  localparam logic [2:0] CAL_DIV_RST = 3'h0;
  localparam logic [5:0] COEF_ADDR_RST = 6'h00;
  localparam logic [5:0] COEF_DATA_RST = 6'h3f;
  localparam logic [5:0] COEF_COEF_RESTORE_DEFAULT = 6'h20;
  localparam int COEF_DEPTH = 64;
  localparam logic [5:0] COEF_LAST = 6'h3f;
  localparam logic [1:0] CAL_ST_COEF_RESTORE_DEFAULT = 2'h0;
  localparam logic [1:0] CAL_ST_SELF = 2'h1;
  localparam logic [1:0] CAL_ST_USER = 2'h3;
  localparam logic [7:0] DIV_FULL_MASK = 8'hff;
  localparam int DIV_SPAN = 256;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum {SPI_IDLE, SPI_INSTR, SPI_DATA, SPI_DONE} dcr_spi_state_t;

endpackage

`default_nettype wire

// >>> tb/dcr_spi_host.sv
`default_nettype none

// ---------------------------------------------
// Serial host model, three-wire, MSB first
// ---------------------------------------------
module dcr_spi_host (
  input wire logic ref_clk,
  input wire logic sdio_line,
  output logic csb_n,
  output logic sclk,
  output logic host_sdio,
  output logic host_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    csb_n = 1'b1;
    sclk = 1'b0;
    host_sdio = 1'b0;
    host_oe = 1'b0;
  end

  // Wait a number of system clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One frame of one or two data bytes; each clock level lasts three edges
  task automatic xfer(input logic rd, input logic [4:0] addr, input logic [15:0] wd,
                      input logic two, output logic [7:0] rdv);
    logic [23:0] sh;
    int top;
    sh = two ? {rd, 2'b01, addr, wd} : {8'h00, rd, 2'b00, addr, wd[7:0]};
    top = two ? 23 : 15;
    rdv = 8'h00;
    @(posedge ref_clk);
    csb_n <= 1'b0;
    host_oe <= 1'b1;
    for (int i = top; i >= 0; i--) begin
      tick(3);
      sclk <= 1'b0;
      // Let go of the line once the device answers
      if (i < 8 && rd) begin
        host_oe <= 1'b0;
      end
      host_sdio <= sh[i];
      tick(3);
      sclk <= 1'b1;
      if (i < 8) begin
        rdv[i] = sdio_line;
      end
    end
    tick(3);
    sclk <= 1'b0;
    tick(3);
    csb_n <= 1'b1;
    host_oe <= 1'b0;
    tick(4);
  endtask
endmodule

`default_nettype wire

// >>> tb/dcr_regs_bench.sv
`default_nettype none

module dcr_regs_bench;
  import dcr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DW = 14;
  localparam logic [3:0] REV = 4'h9; // Arbitrary revision value
  logic ref_clk, sys_rst, csb_n, sclk, host_sdio, host_oe, dev_out, dev_oe, sdo_out, sdo_oe;
  logic last = 1'b0;
  logic samp_clk, samp_diff, cal_clk, ref_sel, clk_type;
  logic [DW-1:0] sdata, scode;
  logic [5:0] trim, a, d;
  logic [7:0] rv;
  logic [4:0] sc_cnt = 5'h0;
  int bad_count, comparisons, rises, p, n;
  // Released line toggles so a stale bit cannot pass
  wire logic sdio_line = dev_oe ? dev_out : (host_oe ? host_sdio : ~last);
  // Host reads the four-wire output while it is enabled
  wire logic rd_line = sdo_oe ? sdo_out : sdio_line;

  dcr_regs #(.DATA_W(DW), .HW_REVISION(REV)) i_dcr_regs (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .spi_csb_n(csb_n), .spi_sclk(sclk),
    .spi_sdio_in(sdio_line), .spi_sdio_out(dev_out), .spi_sdio_oe(dev_oe),
    .spi_sdo_out(sdo_out), .spi_sdo_oe(sdo_oe), .sample_clock_in(samp_clk),
    .sample_clock_in_diff(samp_diff), .sample_data_in(sdata), .cal_trim_in(trim),
    .sample_code_out(scode), .cal_clk_out(cal_clk), .ref_source_select(ref_sel),
    .clock_input_type(clk_type));
  dcr_spi_host i_dcr_spi_host (
    .ref_clk(ref_clk), .sdio_line(rd_line), .csb_n(csb_n), .sclk(sclk),
    .host_sdio(host_sdio), .host_oe(host_oe));

  // System clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Sample clocks: single-ended period 16, differential period 32
  always @(posedge ref_clk) begin
    sc_cnt <= sc_cnt + 5'h1;
    samp_clk <= sc_cnt[3];
    samp_diff <= sc_cnt[4];
    last <= sdio_line;
    if (sc_cnt[3:0] == 4'h7) begin
      rises <= rises + 1;
    end
  end

  // ---------------------------------------------
  // Checking helpers
  // ---------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] ad, input logic [7:0] dv);
    i_dcr_spi_host.xfer(1'b0, ad, {8'h00, dv}, 1'b0, rv);
  endtask

  task automatic rd(input logic [4:0] ad, input logic [7:0] e, input string nm);
    i_dcr_spi_host.xfer(1'b1, ad, 16'h0000, 1'b0, rv);
    check(nm, {8'h00, e}, {8'h00, rv});
  endtask

  // Expected core code: two's complement gets its sign bit flipped
  function automatic logic [DW-1:0] xf(input logic [DW-1:0] v, input logic tc);
    return tc ? {~v[DW-1], v[DW-2:0]} : v;
  endfunction

  // Wait for a level on the calibration clock, bounded
  task automatic lvl_wait(input logic lv);
    int k;
    for (k = 0; k < 20000 && cal_clk !== lv; k++) @(posedge ref_clk);
    if (k == 20000) begin
      bad_count++;
      close_out();
    end
  endtask

  // Sample rises in one full calibration clock period
  task automatic cal_period(output int pr);
    int r0;
    lvl_wait(1'b0);
    lvl_wait(1'b1);
    lvl_wait(1'b0);
    lvl_wait(1'b1);
    r0 = rises;
    lvl_wait(1'b0);
    lvl_wait(1'b1);
    pr = rises - r0;
  endtask

  // Change data just before a sample rise and watch the latency
  task automatic dpath(input logic [7:0] cfg);
    logic [DW-1:0] d0, d1;
    int r, k;
    d0 = DW'($urandom);
    d1 = d0 ^ DW'($urandom | 32'h1);
    wr(ADDR_DATA_CFG, cfg);
    sdata <= d0;
    repeat (48) @(posedge ref_clk);
    r = rises;
    for (k = 0; k < 40 && rises == r; k++) @(posedge ref_clk);
    if (k == 40) begin
      bad_count++;
      close_out();
    end
    sdata <= d1;
    // Rising capture of d1 is 1 edge later, the next fall 9, the next rise 17
    repeat (11) @(posedge ref_clk);
    check("code retimed", {2'b00, xf(cfg[3] ? d0 : d1, cfg[7])}, {2'b00, scode});
    repeat (11) @(posedge ref_clk);
    check("code first", {2'b00, xf(&cfg[4:3] ? d0 : d1, cfg[7])}, {2'b00, scode});
    repeat (32) @(posedge ref_clk);
    check("code settled", {2'b00, xf(d1, cfg[7])}, {2'b00, scode});
  endtask

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    logic [7:0] cfgs [6];
    cfgs = '{8'h00, 8'h80, 8'h08, 8'h88, 8'h10, 8'h18};
    void'($urandom(32'h9326));
    sys_rst = 1'b1;
    sdata = '0;
    trim = '0;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(ADDR_DATA_CFG, 8'h00, "data cfg");
    rd(ADDR_HW_REV, {4'h0, REV}, "revision");
    rd(ADDR_CAL_DIV, 8'h00, "cal div");
    rd(ADDR_CAL_CTL, 8'h00, "cal ctl");
    rd(ADDR_COEF_ADDR, 8'h00, "coef addr");
    rd(ADDR_COEF_DATA, 8'h3f, "coef data");
    rd(5'h05, 8'h00, "unmapped");
    check("ref sel", 16'h0, {15'h0, ref_sel});
    check("clk type", 16'h0, {15'h0, clk_type});
    wr(ADDR_SPI_CTL, 8'h81);
    check("ref sel", 16'h1, {15'h0, ref_sel});
    wr(ADDR_SPI_CTL, 8'h01);
    rd(ADDR_HW_REV, {4'h0, REV}, "four-wire revision");
    wr(ADDR_SPI_CTL, 8'h81);
    a = 6'($urandom);
    d = 6'($urandom);
    wr(ADDR_COEF_ADDR, {2'b00, a});
    wr(ADDR_COEF_DATA, {2'b00, d});
    wr(ADDR_CAL_CTL, 8'h08);
    wr(ADDR_COEF_DATA, {2'b00, ~d});
    wr(ADDR_CAL_CTL, 8'h04);
    rd(ADDR_COEF_DATA, {2'b00, d}, "coef read");
    rd(ADDR_COEF_ADDR, {2'b00, a}, "coef addr");
    rd(ADDR_CAL_DIV, 8'h30, "mem state");
    wr(ADDR_CAL_CTL, 8'h01);
    wr(ADDR_CAL_CTL, 8'h04);
    rd(ADDR_COEF_DATA, {2'b00, COEF_COEF_RESTORE_DEFAULT}, "restored");
    i_dcr_spi_host.xfer(1'b0, ADDR_COEF_DATA, {2'b00, ~d, 2'b00, ~a}, 1'b1, rv);
    rd(ADDR_COEF_DATA, {2'b00, ~d}, "two-byte first");
    rd(ADDR_COEF_ADDR, {2'b00, ~a}, "two-byte second");
    foreach (cfgs[i]) dpath(cfgs[i]);
    wr(ADDR_DATA_CFG, 8'h01);
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CAL_DIV, 8'(c));
      cal_period(p);
      check("divider", 16'(256 >> c), 16'(p));
    end
    wr(ADDR_DATA_CFG, 8'h05);
    check("clk type", 16'h1, {15'h0, clk_type});
    cal_period(p);
    check("diff divider", 16'h4, 16'(p));
    wr(ADDR_DATA_CFG, 8'h00);
    repeat (20) @(posedge ref_clk);
    n = 0;
    repeat (600) begin
      @(posedge ref_clk);
      if (cal_clk !== 1'b0) n++;
    end
    check("cal clk idle", 16'h0, 16'(n));
    trim <= 6'($urandom);
    wr(ADDR_CAL_DIV, 8'h07);
    wr(ADDR_DATA_CFG, 8'h01);
    wr(ADDR_CAL_CTL, 8'h40);
    rv = 8'h00;
    for (n = 0; n < 60 && rv[7] !== 1'b1; n++) begin
      i_dcr_spi_host.xfer(1'b1, ADDR_CAL_CTL, 16'h0000, 1'b0, rv);
    end
    if (rv[7] !== 1'b1) begin
      bad_count++;
      close_out();
    end
    rd(ADDR_CAL_CTL, 8'h80, "cal done");
    rd(ADDR_CAL_DIV, 8'h17, "mem state");
    wr(ADDR_CAL_CTL, 8'h04);
    rd(ADDR_COEF_DATA, {2'b00, trim}, "cal coef");
    wr(ADDR_SPI_CTL, 8'ha1);
    rd(ADDR_SPI_CTL, 8'h81, "ctl kept");
    rd(ADDR_DATA_CFG, 8'h00, "data cfg");
    rd(ADDR_CAL_DIV, 8'h00, "cal div");
    rd(ADDR_COEF_ADDR, 8'h00, "coef addr");
    rd(ADDR_COEF_DATA, 8'h3f, "coef data");
    check("ref sel", 16'h1, {15'h0, ref_sel});
    close_out();
  end
endmodule

`default_nettype wire
